// ===== hw/brc_top.sv
// reset sequencing, reset cause, strap latch and board-ready control
// assumes board reset, switch and strap inputs timed to clk_i and a
// classic wishbone master; rst_n_i is the block's own bring-up reset
//
// Decided for this implementation: the register offsets and the Wishbone register port.

// Functional notes
// - sample straps, latch at power-up release
// - straps pass several cascaded register stages
// - system reset spares memory refresh logic
// - ignore bus cycles until both resets released; code acks every cycle and drops only control writes
// - system reset keeps latched configuration
// - reset-out from power-up, switch, aux, software
// - reset-out never resets internal logic
// - reset-out stretched 100 us after sources
// - switch must hold three seconds
// - abort at once, reset after hold
// - aux input merged into reset-out
// - software bit sticky until system reset
// - capture reset cause at system reset
// - either reset clears ready, drives low
// - ready bit set releases line drive
// - status shows actual ready line level
// - system-controller pin readable by software
module brc_top
  import brc_pkg::*;
#(
  parameter int unsigned SW_HOLD_CYC = SWITCH_HOLD_CYC,
  parameter int unsigned OUT_HOLD_CYC = RESET_OUT_N_HOLD_CYC,
  parameter int unsigned STAGES = STRAP_STAGES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // board reset pins
  input wire logic power_up_reset_n_i,
  input wire logic sys_reset_n_i,
  input wire logic reset_switch_n_i,
  input wire logic abort_switch_n_i,
  input wire logic aux_reset_n_i,
  input wire logic system_controller_n_i,
  input wire logic [STRAP_W-1:0] local_addr_data_bus_i,
  input wire logic req64_n_i,
  output logic reset_out_n_o,
  // open-drain board-ready line
  input wire logic board_ready_line_i,
  output logic board_ready_line_o,
  output logic board_ready_line_oe_o,
  // resets and status toward the rest of the device
  output logic core_reset_n_o,
  output logic refresh_reset_n_o,
  output logic bus_enable_o,
  output logic abort_o,
  output logic [STRAP_W:0] config_o
);

  localparam int unsigned OW = $clog2(OUT_HOLD_CYC + 1);

  initial begin
    if (STAGES < 2) $error("brc_top: strap path needs at least two stages");
    if (OUT_HOLD_CYC < 1) $error("brc_top: reset-out stretch must be positive");
  end

  // synchronised pins
  logic [5:0] pins_s;
  logic power_up_reset_n_s;
  logic sysrst_s;
  logic sw_s;
  logic abt_s;
  logic aux_s;
  logic system_controller_n_s;
  logic rdy_line_s;

  // internal state
  logic power_up_reset_n_prev_ff;
  logic sysrst_prev_ff;
  logic [STRAP_W:0] strap_pipe_ff [STAGES];
  logic [STRAP_W:0] cfg_ff;
  logic swrst_ff;
  logic nxt_swrst;
  logic rdy_ff;
  logic nxt_rdy;
  logic swen_ff;
  logic nxt_swen;
  logic [2:0] cause_ff;
  logic [OW-1:0] hold_cnt_ff;
  logic [OW-1:0] nxt_hold_cnt;
  logic rst_out_n_ff;
  logic rdy_oe_ff;
  logic core_n_ff;
  logic refresh_n_ff;
  logic bus_en_ff;
  logic abort_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // reset inputs pass two flops before any use
  // these pins reset to their idle high level: no false press, abort or
  // system reset edge follows bring-up
  brc_sync #(
    .W(6),
    .RST_VAL(1'b1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({board_ready_line_i, system_controller_n_i, aux_reset_n_i,
          abort_switch_n_i, reset_switch_n_i, sys_reset_n_i}),
    .q_o(pins_s)
  );

  // power-up reset has its own synchroniser so it can reset to asserted
  brc_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_sync_pu (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(power_up_reset_n_i),
    .q_o(power_up_reset_n_s)
  );

  // active-high views of the synchronised pins
  assign sysrst_s = !pins_s[0];
  assign sw_s = !pins_s[1];
  assign abt_s = !pins_s[2];
  assign aux_s = !pins_s[3];
  assign system_controller_n_s = !pins_s[4];
  assign rdy_line_s = pins_s[5];

  // switch reset after a continuous three-second hold
  logic sw_held;
  brc_hold_det #(
    .HOLD(SW_HOLD_CYC)
  ) u_hold (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(sw_s),
    .held_o(sw_held)
  );

  // reset events
  logic pu_active;
  logic core_rst;
  logic pwr_rel;
  logic sys_fall;
  logic sys_cap;
  assign pu_active = !power_up_reset_n_s;
  assign core_rst = pu_active || sysrst_s;
  assign pwr_rel = power_up_reset_n_prev_ff == 1'b0 && power_up_reset_n_s;
  assign sys_fall = !sysrst_prev_ff && sysrst_s;
  // power-up reset wipes the cause, so a capture only counts without it
  assign sys_cap = sys_fall && !pu_active;

  // wishbone decode; writes are dropped while the core is in reset
  logic wb_req;
  logic wr_ctrl;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_cfg;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign sel_ctrl = wb_adr_i[7:2] == ADDR_CTRL[7:2];
  assign sel_stat = wb_adr_i[7:2] == ADDR_STAT[7:2];
  assign sel_cfg = wb_adr_i[7:2] == ADDR_CFG[7:2];
  assign wr_ctrl = wb_req && wb_we_i && sel_ctrl && wb_sel_i[0] && !core_rst;

  // software reset bit can only be set; system or power-up reset clears it
  assign nxt_swrst = core_rst ? 1'b0 : (swrst_ff || (wr_ctrl && wb_dat_i[CTRL_SWRST_BIT]));
  // ready bit cleared by either reset, otherwise software-owned
  assign nxt_rdy = core_rst ? 1'b0 : wr_ctrl ? wb_dat_i[CTRL_RDY_BIT] : rdy_ff;
  assign nxt_swen = pu_active ? CTRL_SWEN_RST : wr_ctrl ? wb_dat_i[CTRL_SWEN_BIT] : swen_ff;

  // reset-out sources, aux merged in; no path back into core resets
  logic reset_out_n_src;
  assign reset_out_n_src = pu_active || (sw_held && swen_ff) || aux_s || swrst_ff;

  // stretch counter reloads while any source is present
  assign nxt_hold_cnt = reset_out_n_src ? OW'(OUT_HOLD_CYC) :
                        (hold_cnt_ff != '0) ? hold_cnt_ff - 1'b1 : hold_cnt_ff;

  // read data mux
  logic [31:0] stat_w;
  logic [31:0] ctrl_w;
  logic [31:0] rmux;
  always_comb begin
    stat_w = '0;
    stat_w[STAT_CAUSE_AUX_BIT:STAT_CAUSE_SW_BIT] = cause_ff;
    stat_w[STAT_RDY_SENSE_BIT] = rdy_line_s;
    stat_w[STAT_SYSCON_BIT] = system_controller_n_s;
    stat_w[STAT_BUS_LIVE_BIT] = bus_en_ff;
    stat_w[STAT_ABORT_BIT] = abort_ff;
  end
  always_comb begin
    ctrl_w = '0;
    ctrl_w[CTRL_SWRST_BIT] = swrst_ff;
    ctrl_w[CTRL_RDY_BIT] = rdy_ff;
    ctrl_w[CTRL_SWEN_BIT] = swen_ff;
  end
  assign rmux = sel_ctrl ? ctrl_w : sel_stat ? stat_w : sel_cfg ? 32'(cfg_ff) : 32'h0000_0000;

  // reset edge trackers for power-up and system reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_up_reset_n_prev_ff <= 1'b0;
      sysrst_prev_ff <= 1'b0;
    end else begin
      power_up_reset_n_prev_ff <= power_up_reset_n_s;
      sysrst_prev_ff <= sysrst_s;
    end
  end

  // straps cascade through several stages before use
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STAGES; i++) strap_pipe_ff[i] <= '0;
    end else begin
      strap_pipe_ff[0] <= {!req64_n_i, local_addr_data_bus_i};
      for (int i = 1; i < STAGES; i++) strap_pipe_ff[i] <= strap_pipe_ff[i-1];
    end
  end

  // configuration loads only on power-up release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_ff <= '0;
    end else if (pwr_rel) begin
      cfg_ff <= strap_pipe_ff[STAGES-1];
    end
  end

  // software-visible control bits
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      swrst_ff <= 1'b0;
      rdy_ff <= 1'b0;
      swen_ff <= CTRL_SWEN_RST;
    end else begin
      swrst_ff <= nxt_swrst;
      rdy_ff <= nxt_rdy;
      swen_ff <= nxt_swen;
    end
  end

  // reset cause captured at system reset entry, cleared only by power-up
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || pu_active) begin
      cause_ff <= '0;
    end else if (sys_fall) begin
      cause_ff <= {aux_s, sw_held, swrst_ff};
    end
  end

  // reset-out and board-ready enable outputs, both from flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_cnt_ff <= OW'(OUT_HOLD_CYC);
      rst_out_n_ff <= 1'b0;
      rdy_oe_ff <= 1'b1;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
      rst_out_n_ff <= !(reset_out_n_src || nxt_hold_cnt != '0);
      rdy_oe_ff <= !nxt_rdy;
    end
  end

  // internal resets, bus gate and abort level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      core_n_ff <= 1'b0;
      refresh_n_ff <= 1'b0;
      bus_en_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      core_n_ff <= !core_rst;
      refresh_n_ff <= !pu_active;
      bus_en_ff <= !core_rst;
      abort_ff <= abt_s;
    end
  end

  // wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff <= wb_req;
      rdat_ff <= wb_req ? rmux : rdat_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign reset_out_n_o = rst_out_n_ff;
  assign board_ready_line_o = 1'b0;
  assign board_ready_line_oe_o = rdy_oe_ff;
  assign core_reset_n_o = core_n_ff;
  assign refresh_reset_n_o = refresh_n_ff;
  assign bus_enable_o = bus_en_ff;
  assign abort_o = abort_ff;
  assign config_o = cfg_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_strap_latch: assert property (pwr_rel |=> cfg_ff == $past(strap_pipe_ff[STAGES-1]))
    else $error("straps not latched at power-up release");
  chk_cfg_kept: assert property (!pwr_rel |=> $stable(cfg_ff))
    else $error("configuration changed without power-up release");
  chk_reset_out_n_src: assert property (reset_out_n_src |=> !reset_out_n_o)
    else $error("reset-out not asserted with a source present");
  chk_reset_out_n_hold: assert property ($fell(reset_out_n_src) |-> !reset_out_n_o [*8])
    else $error("reset-out released too early");
  chk_sw_sticky: assert property (swrst_ff && !core_rst |=> swrst_ff)
    else $error("software reset bit dropped without system reset");
  chk_ready_drive: assert property (core_rst |=> board_ready_line_oe_o)
    else $error("ready line not driven low during reset");
  chk_ready_free: assert property (rdy_ff |-> !board_ready_line_oe_o)
    else $error("ready line still driven after ready bit set");
  chk_bus_gate: assert property (core_rst |=> !bus_enable_o && !core_reset_n_o)
    else $error("bus enabled while a reset input is active");
  chk_cause_cap: assert property (sys_cap |=> cause_ff == $past({aux_s, sw_held, swrst_ff}))
    else $error("reset cause not captured");
  chk_refresh_kept: assert property (sysrst_s && !pu_active |=> refresh_reset_n_o)
    else $error("refresh logic reset by system reset");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_out_free: assert property (hold_cnt_ff == OW'(1) && !reset_out_n_src |=> reset_out_n_o)
    else $error("reset-out not released after the stretch");
  chk_abort_now: assert property (abt_s |=> abort_o)
    else $error("abort level not raised at once");

  // main scenarios worth seeing at least once
  cov_sys_cause: cover property (sys_cap);
  cov_sw_reset: cover property (wr_ctrl && wb_dat_i[CTRL_SWRST_BIT] ##1 !reset_out_n_o);
  cov_switch_hold: cover property (sw_held && swen_ff ##1 !reset_out_n_o);
  cov_power_release: cover property (pwr_rel);
  cov_ready_up: cover property ($fell(board_ready_line_oe_o));

endmodule : brc_top

// ===== shared/brc_pkg.sv
// constants for the bridge reset and ready control block
// assumes a 40 MHz core clock and a 32-bit classic wishbone register port
package brc_pkg;

  // clock rate and derived timing
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned RESET_OUT_N_HOLD_US = 100;
  localparam int unsigned RESET_OUT_N_HOLD_CYC = (RESET_OUT_N_HOLD_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned SWITCH_HOLD_MS = 3000;
  localparam int unsigned SWITCH_HOLD_CYC = SWITCH_HOLD_MS * CLK_KHZ;
  localparam int unsigned HOLD_CNT_W = 12;

  // strap capture
  localparam int unsigned STRAP_W = 31;
  localparam int unsigned STRAP_STAGES = 3;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;

  // control register fields and reset values
  localparam int unsigned CTRL_SWRST_BIT = 0;
  localparam int unsigned CTRL_RDY_BIT = 1;
  localparam int unsigned CTRL_SWEN_BIT = 2;
  localparam logic CTRL_SWEN_RST = 1'b1;

  // status register fields
  localparam int unsigned STAT_CAUSE_SW_BIT = 0;
  localparam int unsigned STAT_CAUSE_SWITCH_BIT = 1;
  localparam int unsigned STAT_CAUSE_AUX_BIT = 2;
  localparam int unsigned STAT_RDY_SENSE_BIT = 3;
  localparam int unsigned STAT_SYSCON_BIT = 4;
  localparam int unsigned STAT_BUS_LIVE_BIT = 5;
  localparam int unsigned STAT_ABORT_BIT = 6;

  // configuration register: straps in low bits, 64-bit request strap on top
  localparam int unsigned CFG_REQ64_BIT = 31;

endpackage : brc_pkg

// ===== hw/brc_sync.sv
// two-stage synchroniser, one per bit
// assumes a synchronous active-low reset on the destination clock
module brc_sync #(
  parameter int unsigned W = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  initial begin
    if (W < 1) $error("brc_sync: width must be at least one");
  end

  // first stage feeds only the second stage
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta_ff <= RST_VAL;
          sync_ff <= RST_VAL;
        end else begin
          meta_ff <= d_i[gi];
          sync_ff <= meta_ff;
        end
      end
      assign q_o[gi] = sync_ff;
    end
  endgenerate

endmodule : brc_sync

// ===== hw/brc_hold_det.sv
// hold detector: output rises once the input has been high for HOLD cycles
// assumes a level already synchronised to clk_i
module brc_hold_det #(
  parameter int unsigned HOLD = 120000000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic held_o
);

  localparam int unsigned CW = $clog2(HOLD + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic held_ff;
  logic nxt_held;

  initial begin
    if (HOLD < 1) $error("brc_hold_det: HOLD must be at least one");
  end

  // count restarts whenever the input drops, saturates at HOLD
  assign nxt_cnt = !level_i ? '0 : (cnt_ff == CW'(HOLD)) ? cnt_ff : cnt_ff + 1'b1;
  assign nxt_held = level_i && (nxt_cnt == CW'(HOLD));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      held_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      held_ff <= nxt_held;
    end
  end

  assign held_o = held_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_short_press: assert property (!level_i |=> !held_o)
    else $error("hold output high after input dropped");
  chk_full_hold: assert property ((cnt_ff == CW'(HOLD - 1)) && level_i |=> held_o)
    else $error("hold output missing after full delay");

endmodule : brc_hold_det

// ===== sim/brc_board_model.sv
// board side of the reset block: reset generator and shared ready line
// assumes the caller starts each task just after a rising edge of clk_i
module brc_board_model #(
  parameter int PWR_CYC = 2000,
  parameter int SYS_CYC = 100
) (
  input wire logic clk_i,
  input wire logic ready_oe_i,
  input wire logic ready_o_i,
  output logic power_up_reset_n_o,
  output logic sys_reset_n_o,
  output logic ready_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic other_busy; // another board still holds the ready line low

  // wired line with a pull-up: low while any board drives it
  assign ready_line_o = ((ready_oe_i && !ready_o_i) || other_busy) ? 1'b0 : 1'b1;

  // bring-up: system reset released before power-up reset
  initial begin
    power_up_reset_n_o = 1'b0;
    sys_reset_n_o = 1'b0;
    other_busy = 1'b1;
    repeat (SYS_CYC) @(posedge clk_i);
    sys_reset_n_o <= 1'b1;
    repeat (PWR_CYC) @(posedge clk_i);
    power_up_reset_n_o <= 1'b1;
  end

  // power-up reset pulse, never shorter than the minimum
  task pwr_pulse();
    power_up_reset_n_o <= 1'b0;
    repeat (PWR_CYC) @(posedge clk_i);
    power_up_reset_n_o <= 1'b1;
  endtask : pwr_pulse

  // system reset pulse of the minimum length
  task sys_pulse();
    sys_reset_n_o <= 1'b0;
    repeat (SYS_CYC) @(posedge clk_i);
    sys_reset_n_o <= 1'b1;
  endtask : sys_pulse

  // another board releases or grabs the ready line
  task set_other(input logic busy);
    other_busy <= busy;
  endtask : set_other
endmodule : brc_board_model

// ===== sim/brc_top_test.sv
// testbench of the reset block: wishbone tasks and directed scenarios
// assumes brc_pkg compiled first and the board model beside this file
module brc_top_test;
  import brc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SW_HOLD = 20;
  localparam int OUT_HOLD = 10;
  localparam logic [30:0] STRAP_A = 31'h2a5a1c3e;
  localparam logic [30:0] STRAP_B = 31'h15a5e3c1;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic sw_n = 1'b1; // one switch feeds reset and abort inputs
  logic aux_n = 1'b1;
  logic system_controller_n_n = 1'b1;
  logic [30:0] local_addr_data_bus = STRAP_A;
  logic req64_n = 1'b0;
  logic pwr_n, sys_n, rdy_line, rdy_o, rdy_oe, rst_out_n;
  logic core_n, refresh_n, bus_en, abort;
  logic [31:0] cfg;
  int bad_count = 0;
  int n_compared = 0;
  int n;

  always #12.5 clk = ~clk;

  brc_top #(.SW_HOLD_CYC(SW_HOLD), .OUT_HOLD_CYC(OUT_HOLD)) i_brc_top (
    .clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .power_up_reset_n_i(pwr_n), .sys_reset_n_i(sys_n),
    .reset_switch_n_i(sw_n), .abort_switch_n_i(sw_n), .aux_reset_n_i(aux_n),
    .system_controller_n_i(system_controller_n_n), .local_addr_data_bus_i(local_addr_data_bus), .req64_n_i(req64_n),
    .reset_out_n_o(rst_out_n), .board_ready_line_i(rdy_line), .board_ready_line_o(rdy_o),
    .board_ready_line_oe_o(rdy_oe), .core_reset_n_o(core_n), .refresh_reset_n_o(refresh_n),
    .bus_enable_o(bus_en), .abort_o(abort), .config_o(cfg));

  brc_board_model i_brc_board_model (
    .clk_i(clk), .ready_oe_i(rdy_oe), .ready_o_i(rdy_o), .power_up_reset_n_o(pwr_n),
    .sys_reset_n_o(sys_n), .ready_line_o(rdy_line));

  // compare one value and count it
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one classic wishbone cycle, entered just after a rising edge
  task wb_acc(input logic we, input logic [7:0] adr, input logic [31:0] d,
              output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_wdat <= d;
    // no limit here: only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
  endtask : wb_acc

  task wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb_acc(1'b1, adr, d, q);
  endtask : wr

  // read and compare the masked bits
  task rd(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] q;
    wb_acc(1'b0, adr, 32'h0, q);
    check(q & mask, exp);
  endtask : rd

  // count edges until reset-out shows the wanted level
  task wait_out(input logic lvl, input int maxc);
    n = 0;
    while (rst_out_n !== lvl && n < maxc) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_out

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction : inr

  task results();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // watchdog well beyond the expected run of about 4400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    check({30'h0, rst_out_n, refresh_n}, 32'h0);
    wait_out(1'b1, 3000);
    check({31'h0, bus_en}, 32'h1);
    rd(ADDR_CFG, 32'hffffffff, {1'b1, STRAP_A});
    rd(ADDR_CTRL, 32'hffffffff, 32'h4);
    rd(8'h0c, 32'hffffffff, 32'h0);
    rd(ADDR_STAT, 32'h27, 32'h20);
    $display("test power-up done");
    // auxiliary source and stretch after release
    aux_n <= 1'b0;
    wait_out(1'b0, 8);
    check(inr(n, 2, 4), 32'h1);
    repeat (5) @(posedge clk);
    check({30'h0, core_n, bus_en}, 32'h3);
    aux_n <= 1'b1;
    wait_out(1'b1, 40);
    check(inr(n, OUT_HOLD, OUT_HOLD + 5), 32'h1);
    $display("test aux done");
    // short press: abort only
    sw_n <= 1'b0;
    repeat (5) @(posedge clk);
    check({31'h0, abort}, 32'h1);
    repeat (SW_HOLD - 8) @(posedge clk);
    sw_n <= 1'b1;
    repeat (6) @(posedge clk);
    check({31'h0, rst_out_n}, 32'h1);
    // long press asserts reset-out after the hold
    sw_n <= 1'b0;
    wait_out(1'b0, SW_HOLD + 12);
    check(inr(n, SW_HOLD, SW_HOLD + 6), 32'h1);
    check({31'h0, core_n}, 32'h1);
    sw_n <= 1'b1;
    wait_out(1'b1, 40);
    // disabled switch never resets
    wr(ADDR_CTRL, 32'h0);
    sw_n <= 1'b0;
    repeat (SW_HOLD + 10) @(posedge clk);
    check({31'h0, rst_out_n}, 32'h1);
    sw_n <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ADDR_CTRL, 32'h4);
    $display("test switch done");
    // ready line and system controller sense
    wr(ADDR_CTRL, 32'h6);
    check({31'h0, rdy_oe}, 32'h0);
    rd(ADDR_STAT, 32'h8, 32'h0);
    i_brc_board_model.set_other(1'b0);
    system_controller_n_n <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ADDR_STAT, 32'h18, 32'h18);
    $display("test ready done");
    // software bit sticks until system reset, cause captured
    wr(ADDR_CTRL, 32'h7);
    wait_out(1'b0, 6);
    check(n, 32'h0);
    wr(ADDR_CTRL, 32'h6);
    rd(ADDR_CTRL, 32'h1, 32'h1);
    local_addr_data_bus <= STRAP_B;
    req64_n <= 1'b1;
    fork
      i_brc_board_model.sys_pulse();
      begin
        repeat (20) @(posedge clk);
        check({28'h0, core_n, refresh_n, bus_en, rdy_oe}, 32'h5);
        wr(ADDR_CTRL, 32'h2);
      end
    join
    repeat (5) @(posedge clk);
    rd(ADDR_CTRL, 32'hffffffff, 32'h4);
    check({31'h0, rdy_oe}, 32'h1);
    rd(ADDR_STAT, 32'h7, 32'h1);
    rd(ADDR_CFG, 32'hffffffff, {1'b1, STRAP_A});
    wait_out(1'b1, 40);
    $display("test system reset done");
    // power-up reset reloads the straps
    i_brc_board_model.pwr_pulse();
    repeat (5) @(posedge clk);
    rd(ADDR_CFG, 32'hffffffff, {1'b0, STRAP_B});
    rd(ADDR_STAT, 32'h7, 32'h0);
    check(cfg, {1'b0, STRAP_B});
    check({31'h0, rdy_o}, 32'h0);
    $display("test power-up reload done");
    results();
  end
endmodule : brc_top_test
